/* File: rtl/msr_pkg.sv */
// Constants for the field-bus slave register command handler
package msr_pkg;
   localparam int          AW          = 7;
   localparam int          BUF_DEPTH   = 128;
   localparam int          NPT         = 80;
   localparam logic [7:0]  FN_READ     = 8'h03;
   localparam logic [7:0]  FN_WR1      = 8'h06;
   localparam logic [7:0]  FN_WRN      = 8'h10;
   localparam logic [7:0]  FN_EXC_BIT  = 8'h80;
   localparam logic [7:0]  EX_FUNC     = 8'h01;
   localparam logic [7:0]  EX_ADDR     = 8'h02;
   localparam logic [7:0]  EX_VAL      = 8'h03;
   localparam logic [7:0]  EX_LOCK     = 8'h08;
   localparam logic [7:0]  EX_HI       = 8'ha0;
   localparam logic [7:0]  EX_LO       = 8'h60;
   localparam logic [7:0]  BCAST_ADDR  = 8'h00;
   localparam logic [15:0] MAX_QTY     = 16'h0010;
   localparam logic [15:0] REG_MEAS    = 16'h0001;
   localparam logic [15:0] REG_ERR     = 16'h0002;
   localparam logic [15:0] REG_DP      = 16'h0003;
   localparam logic [15:0] REG_ADDR    = 16'h0020;
   localparam logic [15:0] REG_ID      = 16'h0021;
   localparam logic [15:0] REG_BAUD    = 16'h0022;
   localparam logic [15:0] REG_LOCK    = 16'h0030;
   localparam logic [15:0] REG_PT0     = 16'h0400;
   localparam logic [15:0] REG_PT1     = 16'h0430;
   localparam logic [15:0] REG_PT2     = 16'h0460;
   localparam logic [15:0] REG_PT3     = 16'h0490;
   localparam logic [15:0] PT_SPAN     = 16'h0028;
   localparam logic [15:0] REG_BL      = 16'h0608;
   localparam logic [15:0] REG_BRIGHT  = 16'h0609;
   localparam logic [15:0] REG_CONTR   = 16'h060a;
   localparam logic [15:0] REG_FITTED  = 16'h060b;
   localparam logic [15:0] REG_PWR     = 16'h060c;
   localparam logic [15:0] REG_INV     = 16'h060e;
   // Arbitrary identification value
   localparam logic [15:0] ID_CODE     = 16'h5a5a;
   localparam logic [15:0] PT_FREE     = 16'h8000;
   localparam logic signed [15:0] PT_MAX = 16'sh270f;
   localparam logic [15:0] ADDR_MAX    = 16'h00f7;
   localparam logic [15:0] BAUD_MAX    = 16'h0007;
   localparam logic [15:0] BL_MAX      = 16'h0002;
   localparam logic [15:0] BRIGHT_MAX  = 16'h0014;
   localparam logic [15:0] CONTR_MAX   = 16'h000a;
   localparam logic [15:0] BIT_MAX     = 16'h0001;
   localparam logic [7:0]  ADDR_RST    = 8'h01;
   localparam logic [2:0]  BAUD_RST    = 3'h4;
   localparam logic [4:0]  BRIGHT_RST  = 5'h14;
   localparam logic [3:0]  CONTR_RST   = 4'h5;
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;
   localparam logic [AW-1:0] MIN_FRAME = 7'h04;
   localparam logic [AW-1:0] WR1_LEN   = 7'h08;
   localparam logic [AW-1:0] ECHO_LEN  = 7'h06;
   localparam logic [AW-1:0] EXC_LEN   = 7'h03;
endpackage

/* File: rtl/msr_core.sv */
// Field-bus RTU slave: frame check, register read/write, reply builder
// Contract
// - Only functions 03h, 06h, 10h; else exception 01h
// - Unknown register 02h, bad value 03h
// - Write while locked gives exception 08h
// - A0h/60h only for single read of 01h
// - Failure reply: address, function|80h, code, CRC
// - Address change reply uses old address
// - Baud change reply uses new rate
// - Broadcast executes but never replies
// - Remote may set lock, never clear it
// - X equal 8000h marks point undefined
// - Point defined after X and Y written
// - Backlight 0 permanent, 1 temporary
// - Brightness accepts 0 to 20
// - Contrast accepts 0 to 10
// - Display-fitted register read-only, reports fitting
// - Display power register: 0 on, 1 off
// - Display invert register: 0 normal, 1 reversed
// - Registers 01h, 02h, 03h: value, error, point
// - Single write reply echoes the request
// - Read reply: count twice registers, high first
// - Register 21h returns identification code
`timescale 1ns/1ps
module msr_core (
   input  wire logic          CLK,
   input  wire logic          SYS_RST,
   input  wire logic          CE,
   input  wire logic          RX_VALID,
   input  wire logic [7:0]    RX_DATA,
   input  wire logic          RX_END,
   input  wire logic          TX_READY,
   output logic               TX_VALID,
   output logic [7:0]         TX_DATA,
   output logic               TX_LAST,
   input  wire logic [15:0]   MEAS_VALUE,
   input  wire logic [15:0]   MEAS_ERR,
   input  wire logic [15:0]   MEAS_DP,
   input  wire logic          MEAS_OVER,
   input  wire logic          MEAS_UNDER,
   input  wire logic          DISP_FITTED,
   input  wire logic          LOCAL_UNLOCK,
   output logic [7:0]         SLAVE_ADDR,
   output logic [2:0]         BAUD_SEL,
   output logic               WR_LOCK,
   output logic               BACKLIGHT_TEMP,
   output logic [4:0]         BRIGHTNESS,
   output logic [3:0]         CONTRAST,
   output logic               DISP_OFF,
   output logic               DISP_INVERT,
   output logic [msr_pkg::NPT-1:0] PT_DEFINED
);
   import msr_pkg::*;

   typedef enum logic [2:0] {S_RX, S_CHK, S_RD, S_VAL, S_WR, S_TX} msr_state_e;

   msr_state_e     st_q;
   logic [7:0]     rxb [BUF_DEPTH];
   logic [7:0]     txb [BUF_DEPTH];
   logic [15:0]    pts [2*NPT];
   logic [AW-1:0]  rcnt_q;
   logic           ovf_q;
   logic [15:0]    rcrc_q;
   logic [15:0]    tcrc_q;
   logic [4:0]     i_q;
   logic [4:0]     n_q;
   logic [7:0]     exc_q;
   logic           echo_q;
   logic [AW-1:0]  tk_q;
   logic [1:0]     bl_q;
   logic           fit_s1_q;
   logic           fit_s2_q;
   logic [NPT-1:0] xw_q;
   logic [NPT-1:0] yw_q;
   logic [7:0]     fn;
   logic [15:0]    start_w;
   logic [15:0]    qty_w;
   logic [15:0]    cur_a;
   logic [15:0]    wv;
   logic           bcast_w;
   logic           last_w;
   logic [AW-1:0]  tlen_w;
   logic [8:0]     pt_w;
   logic [16:0]    rd_w;
   logic [7:0]     chk_w;

   // CRC-16 update, reflected polynomial, one byte
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int j = 0; j < 8; j++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Point table lookup: hit flag and flat word index
   function automatic logic [8:0] pt_find(input logic [15:0] a);
      logic [15:0] o;
      o = 16'h0000;
      pt_find = 9'h000;
      if (a >= REG_PT0 && a < REG_PT0 + PT_SPAN) begin
         o = a - REG_PT0;
      end else if (a >= REG_PT1 && a < REG_PT1 + PT_SPAN) begin
         o = a - REG_PT1 + PT_SPAN;
      end else if (a >= REG_PT2 && a < REG_PT2 + PT_SPAN) begin
         o = a - REG_PT2 + 16'd2 * PT_SPAN;
      end else if (a >= REG_PT3 && a < REG_PT3 + PT_SPAN) begin
         o = a - REG_PT3 + 16'd3 * PT_SPAN;
      end else begin
         return 9'h000;
      end
      pt_find = {1'b1, o[7:0]};
   endfunction

   // Request fields and per-register address and data
   always_comb begin
      fn      = rxb[1];
      start_w = {rxb[2], rxb[3]};
      qty_w   = {rxb[4], rxb[5]};
      cur_a   = start_w + {11'h000, i_q};
      wv      = (fn == FN_WR1) ? qty_w :
                {rxb[{1'b0, i_q, 1'b0} + 7'd7], rxb[{1'b0, i_q, 1'b0} + 7'd8]};
      bcast_w = (rxb[0] == BCAST_ADDR);
      last_w  = (i_q == n_q - 5'd1);
      tlen_w  = (exc_q != 8'h00) ? EXC_LEN : echo_q ? ECHO_LEN :
                ({1'b0, n_q, 1'b0} + EXC_LEN);
      pt_w    = pt_find(cur_a);
   end

   // Register read mux; bit 16 marks an existing register
   always_comb begin
      rd_w = {1'b1, 16'h0000};
      case (cur_a)
         REG_MEAS:   rd_w[15:0] = MEAS_VALUE;
         REG_ERR:    rd_w[15:0] = MEAS_ERR;
         REG_DP:     rd_w[15:0] = MEAS_DP;
         REG_ADDR:   rd_w[15:0] = {8'h00, SLAVE_ADDR};
         REG_ID:     rd_w[15:0] = ID_CODE;
         REG_BAUD:   rd_w[15:0] = {13'h0000, BAUD_SEL};
         REG_LOCK:   rd_w[15:0] = {15'h0000, WR_LOCK};
         REG_BL:     rd_w[15:0] = {14'h0000, bl_q};
         REG_BRIGHT: rd_w[15:0] = {11'h000, BRIGHTNESS};
         REG_CONTR:  rd_w[15:0] = {12'h000, CONTRAST};
         REG_FITTED: rd_w[15:0] = {15'h0000, fit_s2_q};
         REG_PWR:    rd_w[15:0] = {15'h0000, DISP_OFF};
         REG_INV:    rd_w[15:0] = {15'h0000, DISP_INVERT};
         default: begin
            if (pt_w[8]) begin
               rd_w[15:0] = pts[pt_w[7:0]];
            end else begin
               rd_w = 17'h00000;
            end
         end
      endcase
   end

   // Write check: address exists and is writable, value within range
   always_comb begin
      chk_w = 8'h00;
      case (cur_a)
         REG_ADDR:   chk_w = (wv == 16'h0000 || wv > ADDR_MAX) ? EX_VAL : 8'h00;
         REG_BAUD:   chk_w = (wv > BAUD_MAX) ? EX_VAL : 8'h00;
         REG_LOCK:   chk_w = (wv > BIT_MAX) ? EX_VAL : 8'h00;
         REG_BL:     chk_w = (wv > BL_MAX) ? EX_VAL : 8'h00;
         REG_BRIGHT: chk_w = (wv > BRIGHT_MAX) ? EX_VAL : 8'h00;
         REG_CONTR:  chk_w = (wv > CONTR_MAX) ? EX_VAL : 8'h00;
         REG_PWR:    chk_w = (wv > BIT_MAX) ? EX_VAL : 8'h00;
         REG_INV:    chk_w = (wv > BIT_MAX) ? EX_VAL : 8'h00;
         default: begin
            if (!pt_w[8]) begin
               chk_w = EX_ADDR;
            end else if (!(pt_w[0] == 1'b0 && wv == PT_FREE) &&
                         ($signed(wv) > PT_MAX || $signed(wv) < -PT_MAX)) begin
               chk_w = EX_VAL;
            end
         end
      endcase
   end

   // Pin-level display-fitted strap through two flip-flops
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         fit_s1_q <= 1'b0;
         fit_s2_q <= 1'b0;
      end else if (CE) begin
         fit_s1_q <= DISP_FITTED;
         fit_s2_q <= fit_s1_q;
      end
   end

   // Receive: store bytes, run CRC over the whole frame
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rcnt_q <= '0;
         ovf_q  <= 1'b0;
         rcrc_q <= CRC_INIT;
      end else if (CE) begin
         if (st_q == S_CHK) begin
            rcnt_q <= '0;
            ovf_q  <= 1'b0;
            rcrc_q <= CRC_INIT;
         end else if (st_q == S_RX && RX_VALID) begin
            if (rcnt_q == AW'(BUF_DEPTH - 1)) begin
               ovf_q <= 1'b1;
            end else begin
               rxb[rcnt_q] <= RX_DATA;
               rcnt_q      <= rcnt_q + 7'd1;
               rcrc_q      <= crc_upd(rcrc_q, RX_DATA);
            end
         end
      end
   end

   // Main sequencer: check, decode, per-register loop, reply
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_q   <= S_RX;
         i_q    <= '0;
         n_q    <= '0;
         exc_q  <= 8'h00;
         echo_q <= 1'b0;
      end else if (CE) begin
         case (st_q)
            S_RX: begin
               if (RX_END) begin
                  st_q <= S_CHK;
               end
            end
            S_CHK: begin
               i_q    <= '0;
               exc_q  <= 8'h00;
               echo_q <= 1'b0;
               n_q    <= qty_w[4:0];
               st_q   <= bcast_w ? S_RX : S_TX;
               if (rcnt_q < MIN_FRAME || ovf_q || rcrc_q != 16'h0000 ||
                   (rxb[0] != SLAVE_ADDR && !bcast_w)) begin
                  st_q <= S_RX;
               end else if (fn == FN_READ) begin
                  if (qty_w == 16'h0000 || qty_w > MAX_QTY) begin
                     exc_q <= EX_VAL;
                  end else begin
                     st_q <= S_RD;
                  end
               end else if (fn == FN_WR1) begin
                  n_q <= 5'd1;
                  if (rcnt_q != WR1_LEN) begin
                     exc_q <= EX_VAL;
                  end else begin
                     st_q <= S_VAL;
                  end
               end else if (fn == FN_WRN) begin
                  if (qty_w == 16'h0000 || qty_w > MAX_QTY ||
                      rxb[6] != {qty_w[6:0], 1'b0} ||
                      {9'h000, rcnt_q} != 16'd9 + {qty_w[14:0], 1'b0}) begin
                     exc_q <= EX_VAL;
                  end else begin
                     st_q <= S_VAL;
                  end
               end else begin
                  exc_q <= EX_FUNC;
               end
            end
            S_RD: begin
               if (!rd_w[16]) begin
                  exc_q <= EX_ADDR;
                  st_q  <= bcast_w ? S_RX : S_TX;
               end else if (n_q == 5'd1 && cur_a == REG_MEAS && MEAS_OVER) begin
                  exc_q <= EX_HI;
                  st_q  <= bcast_w ? S_RX : S_TX;
               end else if (n_q == 5'd1 && cur_a == REG_MEAS && MEAS_UNDER) begin
                  exc_q <= EX_LO;
                  st_q  <= bcast_w ? S_RX : S_TX;
               end else if (last_w) begin
                  st_q <= bcast_w ? S_RX : S_TX;
               end else begin
                  i_q <= i_q + 5'd1;
               end
            end
            S_VAL: begin
               if (WR_LOCK) begin
                  exc_q <= EX_LOCK;
                  st_q  <= bcast_w ? S_RX : S_TX;
               end else if (chk_w != 8'h00) begin
                  exc_q <= chk_w;
                  st_q  <= bcast_w ? S_RX : S_TX;
               end else if (last_w) begin
                  i_q  <= '0;
                  st_q <= S_WR;
               end else begin
                  i_q <= i_q + 5'd1;
               end
            end
            S_WR: begin
               if (last_w) begin
                  echo_q <= 1'b1;
                  st_q   <= bcast_w ? S_RX : S_TX;
               end else begin
                  i_q <= i_q + 5'd1;
               end
            end
            S_TX: begin
               if (TX_VALID && TX_READY && TX_LAST) begin
                  st_q <= S_RX;
               end
            end
            default: st_q <= S_RX;
         endcase
      end
   end

   // Read data into the reply buffer, high byte first
   always_ff @(posedge CLK) begin
      if (CE && st_q == S_RD && rd_w[16]) begin
         txb[{1'b0, i_q, 1'b0} + 7'd3] <= rd_w[15:8];
         txb[{1'b0, i_q, 1'b0} + 7'd4] <= rd_w[7:0];
      end
   end

   // Reply transmit: one byte per handshake, CRC low then high
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         TX_VALID <= 1'b0;
         TX_DATA  <= 8'h00;
         TX_LAST  <= 1'b0;
         tk_q     <= '0;
         tcrc_q   <= CRC_INIT;
      end else if (CE) begin
         if (st_q != S_TX) begin
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
            tk_q     <= '0;
            tcrc_q   <= CRC_INIT;
         end else if (!TX_VALID) begin
            TX_VALID <= 1'b1;
            TX_LAST  <= (tk_q == tlen_w + 7'd1);
            if (tk_q == tlen_w) begin
               TX_DATA <= tcrc_q[7:0];
            end else if (tk_q == tlen_w + 7'd1) begin
               TX_DATA <= tcrc_q[15:8];
            end else if (tk_q == 7'd0) begin
               TX_DATA <= rxb[0];
            end else if (exc_q != 8'h00) begin
               TX_DATA <= (tk_q == 7'd1) ? (fn | FN_EXC_BIT) : exc_q;
            end else if (echo_q || tk_q == 7'd1) begin
               TX_DATA <= rxb[tk_q];
            end else if (tk_q == 7'd2) begin
               TX_DATA <= {2'b00, n_q, 1'b0};
            end else begin
               TX_DATA <= txb[tk_q];
            end
         end else if (TX_READY) begin
            TX_VALID <= 1'b0;
            tk_q     <= tk_q + 7'd1;
            if (tk_q < tlen_w) begin
               tcrc_q <= crc_upd(tcrc_q, TX_DATA);
            end
         end
      end
   end

   // Configuration registers; settings take effect before the reply
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         SLAVE_ADDR     <= ADDR_RST;
         BAUD_SEL       <= BAUD_RST;
         WR_LOCK        <= 1'b0;
         bl_q           <= 2'b00;
         BACKLIGHT_TEMP <= 1'b0;
         BRIGHTNESS     <= BRIGHT_RST;
         CONTRAST       <= CONTR_RST;
         DISP_OFF       <= 1'b0;
         DISP_INVERT    <= 1'b0;
      end else if (CE) begin
         if (LOCAL_UNLOCK) begin
            WR_LOCK <= 1'b0;
         end
         if (st_q == S_WR) begin
            case (cur_a)
               REG_ADDR:   SLAVE_ADDR  <= wv[7:0];
               REG_BAUD:   BAUD_SEL    <= wv[2:0];
               REG_LOCK: begin
                  if (wv[0]) begin
                     WR_LOCK <= 1'b1;
                  end
               end
               REG_BL: begin
                  bl_q           <= wv[1:0];
                  BACKLIGHT_TEMP <= (wv[1:0] == 2'b01);
               end
               REG_BRIGHT: BRIGHTNESS  <= wv[4:0];
               REG_CONTR:  CONTRAST    <= wv[3:0];
               REG_PWR:    DISP_OFF    <= wv[0];
               REG_INV:    DISP_INVERT <= wv[0];
               default: ;
            endcase
         end
      end
   end

   // Characteristic point words and their written flags
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         for (int p = 0; p < NPT; p++) begin
            pts[2*p]   <= PT_FREE;
            pts[2*p+1] <= 16'h0000;
         end
         xw_q <= '0;
         yw_q <= '0;
      end else if (CE && st_q == S_WR && pt_w[8]) begin
         pts[pt_w[7:0]] <= wv;
         if (pt_w[0]) begin
            yw_q[pt_w[7:1]] <= 1'b1;
         end else if (wv == PT_FREE) begin
            xw_q[pt_w[7:1]] <= 1'b0;
            yw_q[pt_w[7:1]] <= 1'b0;
         end else begin
            xw_q[pt_w[7:1]] <= 1'b1;
         end
      end
   end

   // Per-point defined flag for the calculation
   for (genvar p = 0; p < NPT; p++) begin : g_pt
      always_ff @(posedge CLK) begin
         if (SYS_RST) begin
            PT_DEFINED[p] <= 1'b0;
         end else if (CE) begin
            PT_DEFINED[p] <= xw_q[p] & yw_q[p] & (pts[2*p] != PT_FREE);
         end
      end
   end

   // Checks on the sequencer and the outputs
   sequence s_tx_first;
      TX_VALID && tk_q == 7'd0;
   endsequence

   a_crc_drop: assert property (@(posedge CLK) disable iff (SYS_RST)
      CE && st_q == S_CHK && rcrc_q != 16'h0000 |=> st_q == S_RX)
      else $error("bad CRC frame not dropped");
   a_bcast_silent: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_q == S_TX |-> !bcast_w)
      else $error("reply to broadcast");
   a_func_reject: assert property (@(posedge CLK) disable iff (SYS_RST)
      CE && st_q == S_CHK && rcrc_q == 16'h0000 && !ovf_q && rcnt_q >= MIN_FRAME &&
      rxb[0] == SLAVE_ADDR && fn != FN_READ && fn != FN_WR1 && fn != FN_WRN
      |=> st_q == S_TX && exc_q == EX_FUNC)
      else $error("unsupported function not rejected");
   a_lock_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      WR_LOCK && !LOCAL_UNLOCK |=> WR_LOCK)
      else $error("write lock cleared remotely");
   a_bright_range: assert property (@(posedge CLK) disable iff (SYS_RST)
      {11'h000, BRIGHTNESS} <= BRIGHT_MAX && {12'h000, CONTRAST} <= CONTR_MAX)
      else $error("display level out of range");
   a_addr_old: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_tx_first |-> TX_DATA == rxb[0])
      else $error("reply address not the request address");
   a_exc_func: assert property (@(posedge CLK) disable iff (SYS_RST)
      TX_VALID && tk_q == 7'd1 && exc_q != 8'h00 |-> TX_DATA == (fn | FN_EXC_BIT))
      else $error("exception function byte wrong");
   a_read_count: assert property (@(posedge CLK) disable iff (SYS_RST)
      TX_VALID && tk_q == 7'd2 && exc_q == 8'h00 && !echo_q
      |-> TX_DATA == {2'b00, n_q, 1'b0} && fn == FN_READ)
      else $error("read byte count wrong");
   a_lock_reject: assert property (@(posedge CLK) disable iff (SYS_RST)
      CE && st_q == S_VAL && WR_LOCK |=> st_q != S_WR && (exc_q == EX_LOCK))
      else $error("write accepted while locked");
endmodule

/* File: dv/msr_master.sv */
// Field-bus master model: sends requests, accepts reply bytes
`timescale 1ns/1ps
module msr_master (
   input  wire logic       CLK,
   output logic            RX_VALID,
   output logic [7:0]      RX_DATA,
   output logic            RX_END,
   output logic            TX_READY,
   input  wire logic       TX_VALID,
   input  wire logic [7:0] TX_DATA,
   input  wire logic       TX_LAST
);
   logic [7:0] rx_q[$];
   logic       slow = 1'b0;
   int         last_at = -1;
   initial {RX_VALID, RX_DATA, RX_END, TX_READY} = 11'h0;
   // Reply sink; slow mode stalls every other cycle
   always @(negedge CLK) TX_READY <= slow ? ~TX_READY : 1'b1;
   // Collect reply bytes, note where the last-byte flag was seen
   always @(posedge CLK) begin
      if (TX_VALID && TX_READY) begin
         if (TX_LAST) last_at = rx_q.size();
         rx_q.push_back(TX_DATA);
      end
   end
   // Reflected CRC-16 over a byte queue
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // Byte pulses, released data inverted, CRC low byte first
   task automatic send(input logic [7:0] f[$], input logic bad);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0, bad};
      f = {f, c[7:0], c[15:8]};
      foreach (f[i]) begin
         @(negedge CLK) {RX_VALID, RX_DATA} = {1'b1, f[i]};
         @(negedge CLK) {RX_VALID, RX_DATA} = {1'b0, ~f[i]};
      end
      @(negedge CLK) RX_END = 1'b1;
      @(negedge CLK) RX_END = 1'b0;
   endtask
endmodule

/* File: dv/modbus_rtu_slave_regs_test.sv */
// Self-checking bench for the field-bus slave register handler
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module modbus_rtu_slave_regs_test;
   import msr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, over = 1'b0, under = 1'b0, unl = 1'b0, fit = 1'b1;
   logic [15:0] mv = 16'h00ff;
   logic rxv, rxe, txr, txv, txl, lock, blt, doff, dinv;
   logic [7:0] rxd, txd, saddr, sa = 8'h01;
   logic [2:0] baud;
   logic [4:0] bri;
   logic [3:0] con;
   logic [NPT-1:0] ptd;
   int err_total = 0, checks_done = 0;
   always #2 clk = ~clk;
   msr_master msr_master_i (.CLK(clk), .RX_VALID(rxv), .RX_DATA(rxd), .RX_END(rxe),
      .TX_READY(txr), .TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl));
   msr_core msr_core_i (.CLK(clk), .SYS_RST(rst), .CE(1'b1), .RX_VALID(rxv), .RX_DATA(rxd),
      .RX_END(rxe), .TX_READY(txr), .TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl),
      .MEAS_VALUE(mv), .MEAS_ERR(16'h0000), .MEAS_DP(16'h0001), .MEAS_OVER(over),
      .MEAS_UNDER(under), .DISP_FITTED(fit), .LOCAL_UNLOCK(unl), .SLAVE_ADDR(saddr),
      .BAUD_SEL(baud), .WR_LOCK(lock), .BACKLIGHT_TEMP(blt), .BRIGHTNESS(bri),
      .CONTRAST(con), .DISP_OFF(doff), .DISP_INVERT(dinv), .PT_DEFINED(ptd));
   // Verdict and end of run
   task automatic finish_test;
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Send one request, wait for the reply and compare it with its CRC
   task automatic xact(input logic [127:0] rq, input int nr, input logic [127:0] ex,
                       input int ne, input logic bad = 1'b0);
      logic [7:0] f[$], e[$];
      logic [15:0] c;
      int n;
      for (int i = nr - 1; i >= 0; i--) f.push_back(rq[8*i +: 8]);
      for (int i = ne - 1; i >= 0; i--) e.push_back(ex[8*i +: 8]);
      c = msr_master_i.crc16(e);
      if (ne > 0) e = {e, c[7:0], c[15:8]};
      msr_master_i.rx_q.delete();
      msr_master_i.last_at = -1;
      msr_master_i.send(f, bad);
      for (n = 0; n < 600 && msr_master_i.rx_q.size() < e.size(); n++) @(posedge clk);
      `CHK(n < 600, 1'b1)
      if (n == 600) finish_test();
      repeat (40) @(negedge clk);
      `CHK(msr_master_i.rx_q.size(), e.size())
      `CHK(msr_master_i.last_at, e.size() - 1)
      foreach (e[i]) if (i < msr_master_i.rx_q.size()) `CHK(msr_master_i.rx_q[i], e[i])
   endtask
   // Single write: echo when accepted, else an exception frame
   task automatic wr(input logic [15:0] r, input logic [15:0] v, input logic [7:0] code);
      if (code === 8'h00) xact({sa, FN_WR1, r, v}, 6, {sa, FN_WR1, r, v}, 6);
      else xact({sa, FN_WR1, r, v}, 6, {sa, FN_WR1 | FN_EXC_BIT, code}, 3);
   endtask
   // Reads with a stalling sink, identity, quantity over the limit
   task automatic t_read;
      msr_master_i.slow = 1'b1;
      xact(48'h010300010001, 6, 40'h01030200ff, 5);
      msr_master_i.slow = 1'b0;
      mv = 16'h000a;
      xact(48'h010300010003, 6, 72'h010306000a00000001, 9);
      xact(48'h010300210001, 6, {24'h010302, ID_CODE}, 5);
      xact(48'h010300010010, 6, 24'h018302, 3);
      xact(48'h010300010011, 6, 24'h018303, 3);
   endtask
   // Range codes only on a single read of the value register
   task automatic t_range;
      under = 1'b1;
      xact(48'h010300010001, 6, 24'h018360, 3);
      xact(48'h010300010003, 6, 72'h010306000a00000001, 9);
      {under, over} = 2'b01;
      xact(48'h010300010001, 6, 24'h0183a0, 3);
      over = 1'b0;
   endtask
   // Every unsupported function code from 01h to 1Fh
   task automatic t_func;
      for (int f = 1; f < 32; f++) if (!(f inside {3, 6, 16}))
         xact({8'h01, 8'(f), 32'h00010001}, 6, {8'h01, 8'(f) | FN_EXC_BIT, EX_FUNC}, 3);
   endtask
   // Display settings: limits, read-only place, output levels
   task automatic t_disp;
      wr(REG_BRIGHT, 16'h0015, EX_VAL);
      xact({sa, FN_WRN, REG_BRIGHT, 16'h0002, 8'h04, 32'h00030004}, 11,
           {sa, FN_WRN, REG_BRIGHT, 16'h0002}, 6);
      `CHK({bri, con}, 9'h034)
      xact({sa, FN_READ, REG_FITTED, 16'h0001}, 6, {sa, FN_READ, 8'h02, 16'h0001}, 5);
      fit = 1'b0;
      xact({sa, FN_READ, REG_FITTED, 16'h0001}, 6, {sa, FN_READ, 8'h02, 16'h0000}, 5);
      wr(REG_BRIGHT, 16'h0000, 8'h00);
      wr(REG_CONTR, 16'h000b, EX_VAL);
      wr(REG_CONTR, 16'h000a, 8'h00);
      `CHK({bri, con}, 9'h00a)
      wr(REG_FITTED, 16'h0001, EX_ADDR);
      wr(16'h0700, 16'h0000, EX_ADDR);
      wr(REG_BL, 16'h0001, 8'h00);
      wr(REG_PWR, 16'h0001, 8'h00);
      wr(REG_INV, 16'h0001, 8'h00);
      `CHK({blt, doff, dinv}, 3'h7)
      wr(REG_BL, 16'h0000, 8'h00);
      `CHK(blt, 1'b0)
   endtask
   // Point defined by X and Y, freed again by X of 8000h
   task automatic t_pt;
      wr(REG_PT0, 16'h0005, 8'h00);
      `CHK(ptd[0], 1'b0)
      wr(REG_PT0 + 16'h0001, 16'h0007, 8'h00);
      wr(REG_PT0, 16'h0009, 8'h00);
      `CHK(ptd[0], 1'b1)
      wr(REG_PT0, PT_FREE, 8'h00);
      `CHK(ptd[0], 1'b0)
   endtask
   // Remote lock set, refused clear, local unlock
   task automatic t_lock;
      wr(REG_LOCK, 16'h0001, 8'h00);
      wr(REG_BRIGHT, 16'h0005, EX_LOCK);
      wr(REG_LOCK, 16'h0000, EX_LOCK);
      `CHK({lock, bri}, 6'h20)
      unl = 1'b1;
      @(negedge clk) unl = 1'b0;
      @(negedge clk) `CHK(lock, 1'b0)
   endtask
   // Broadcast, bad CRC, baud and address changes
   task automatic t_addr;
      xact(48'h000600220005, 6, 0, 0);
      `CHK(baud, 3'h5)
      xact(48'h010300010001, 6, 0, 0, 1'b1);
      wr(REG_BAUD, 16'h0006, 8'h00);
      `CHK(baud, 3'h6)
      wr(REG_ADDR, 16'h0002, 8'h00);
      sa = 8'h02;
      `CHK(saddr, 8'h02)
      xact(48'h010300210001, 6, 0, 0);
      xact(48'h020300210001, 6, {24'h020302, ID_CODE}, 5);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      `CHK({saddr, baud, bri, con}, {ADDR_RST, BAUD_RST, BRIGHT_RST, CONTR_RST})
      t_read();
      t_range();
      t_func();
      t_disp();
      t_pt();
      t_lock();
      t_addr();
      finish_test();
   end
endmodule
